// ---- logic/ldo_voltage_control_regs.sv ----
// Purpose: voltage code registers and rail on/off control for the linear regulators
// Assumes: host register access already decoded from the serial bus into strobes
// Notes:   pins pass two flip-flops; sequence step time is a parameter
`timescale 1ns/1ps
`default_nettype none
`include "ldo_ctrl_consts.svh"
module ldo_voltage_control_regs #(
	parameter int unsigned SEQ_STEP_CYCLES = `SEQ_STEP_CYC,
	parameter bit          FIXED_OPTION    = 1'b0
) (
	input  wire logic        i_clk_sys,
	input  wire logic        i_rst,
	input  wire logic        i_reg_wr,
	input  wire logic        i_reg_rd,
	input  wire logic [7:0]  i_reg_addr,
	input  wire logic [7:0]  i_reg_wdata,
	output logic      [7:0]  o_reg_rdata,
	input  wire logic        i_seq_enable_pin,
	input  wire logic [3:0]  i_rail_enable_pins,
	output logic      [3:0]  o_rail_on,
	output logic      [11:0] o_reg_one_mv,
	output logic      [11:0] o_reg_two_mv
);
	// step counter is 24 bits wide, so longer steps cannot be served
	if (SEQ_STEP_CYCLES < 1 || SEQ_STEP_CYCLES > 32'hFFFFFF) begin : g_bad_step
		$error("SEQ_STEP_CYCLES out of range");
	end

	ldo_ctrl_pkg::vcode_t     first_regulator_voltage_code;
	ldo_ctrl_pkg::vcode_t     second_regulator_voltage_code;
	logic [3:0]               bus_rail_en;
	logic [3:0]               seq_rails;
	logic [1:0]               seq_ptr;
	logic [23:0]              step_cnt;
	logic [1:0]               seq_sync;
	logic [3:0]               pin_meta;
	logic [3:0]               pin_sync;
	ldo_ctrl_pkg::seq_state_e state;

	// pins come from outside the clock domain
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			seq_sync <= 2'h0;
			pin_meta <= 4'h0;
			pin_sync <= 4'h0;
		end else begin
			seq_sync <= {seq_sync[0], i_seq_enable_pin};
			pin_meta <= i_rail_enable_pins;
			pin_sync <= pin_meta;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			first_regulator_voltage_code  <= `VCODE_RST;
			second_regulator_voltage_code <= `VCODE_RST;
			bus_rail_en                   <= `RAIL_EN_RST;
		end else if (i_reg_wr) begin
			case (i_reg_addr)
				`LINEAR_REG_ONE_VOLTAGE_OFS: begin
					first_regulator_voltage_code <= i_reg_wdata[`VCODE_MSB:`VCODE_LSB];
				end
				`LINEAR_REG_TWO_VOLTAGE_OFS: begin
					second_regulator_voltage_code <= i_reg_wdata[`VCODE_MSB:`VCODE_LSB];
				end
				`RAIL_ENABLE_OFS: begin
					bus_rail_en <= i_reg_wdata[3:0];
				end
				default: begin
				end
			endcase
		end
	end

	// read data registered; unmapped offsets read zero
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			o_reg_rdata <= 8'h00;
		end else if (i_reg_rd) begin
			case (i_reg_addr)
				`LINEAR_REG_ONE_VOLTAGE_OFS: o_reg_rdata <= {3'h0, first_regulator_voltage_code};
				`LINEAR_REG_TWO_VOLTAGE_OFS: o_reg_rdata <= {3'h0, second_regulator_voltage_code};
				`RAIL_ENABLE_OFS:            o_reg_rdata <= {o_rail_on, bus_rail_en};
				default:                     o_reg_rdata <= 8'h00;
			endcase
		end
	end

	// sequencer: one rail per step, up in order 0..3, down in reverse
	// supply settling before the pin rises is the host's duty, not checked here
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			state     <= ldo_ctrl_pkg::SEQ_OFF;
			seq_rails <= 4'h0;
			seq_ptr   <= 2'h0;
			step_cnt  <= 24'h000000;
		end else begin
			case (state)
				ldo_ctrl_pkg::SEQ_OFF: begin
					if (seq_sync[1]) begin
						state    <= ldo_ctrl_pkg::SEQ_UP;
						seq_ptr  <= 2'h0;
						step_cnt <= 24'h000000;
					end
				end
				ldo_ctrl_pkg::SEQ_UP: begin
					if (!seq_sync[1]) begin
						state    <= ldo_ctrl_pkg::SEQ_DOWN;
						step_cnt <= 24'h000000;
					end else if (step_cnt == 24'(SEQ_STEP_CYCLES - 1)) begin
						step_cnt           <= 24'h000000;
						seq_rails[seq_ptr] <= 1'b1;
						if (seq_ptr == 2'h3) begin
							state <= ldo_ctrl_pkg::SEQ_ON;
						end else begin
							seq_ptr <= seq_ptr + 2'h1;
						end
					end else begin
						step_cnt <= step_cnt + 24'h000001;
					end
				end
				ldo_ctrl_pkg::SEQ_ON: begin
					if (!seq_sync[1]) begin
						state    <= ldo_ctrl_pkg::SEQ_DOWN;
						step_cnt <= 24'h000000;
					end
				end
				ldo_ctrl_pkg::SEQ_DOWN: begin
					if (step_cnt == 24'(SEQ_STEP_CYCLES - 1)) begin
						step_cnt           <= 24'h000000;
						seq_rails[seq_ptr] <= 1'b0;
						if (seq_ptr == 2'h0) begin
							state <= ldo_ctrl_pkg::SEQ_OFF;
						end else begin
							seq_ptr <= seq_ptr - 2'h1;
						end
					end else begin
						step_cnt <= step_cnt + 24'h000001;
					end
				end
				default: begin
					state <= ldo_ctrl_pkg::SEQ_OFF;
				end
			endcase
		end
	end

	// any of the three methods turns a rail on
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			o_rail_on <= 4'h0;
		end else begin
			o_rail_on <= seq_rails | pin_sync | bus_rail_en;
		end
	end

	logic [11:0] one_mv;
	logic [11:0] two_mv;

	ldo_vcode_decode u_dec_one (
		.i_code         (first_regulator_voltage_code),
		.i_fixed_option (FIXED_OPTION),
		.o_mv           (one_mv)
	);
	ldo_vcode_decode u_dec_two (
		.i_code         (second_regulator_voltage_code),
		.i_fixed_option (FIXED_OPTION),
		.o_mv           (two_mv)
	);

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			o_reg_one_mv <= 12'h000;
			o_reg_two_mv <= 12'h000;
		end else begin
			o_reg_one_mv <= one_mv;
			o_reg_two_mv <= two_mv;
		end
	end

	a_reg_one_write: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		i_reg_wr && i_reg_addr == `LINEAR_REG_ONE_VOLTAGE_OFS
		|=> first_regulator_voltage_code == $past(i_reg_wdata[4:0]))
		else $error("regulator one code not stored");
	a_reg_two_write: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		i_reg_wr && i_reg_addr == `LINEAR_REG_TWO_VOLTAGE_OFS
		|=> second_regulator_voltage_code == $past(i_reg_wdata[4:0]))
		else $error("regulator two code not stored");
	a_reserved_read_zero: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		i_reg_rd && (i_reg_addr == `LINEAR_REG_ONE_VOLTAGE_OFS
		|| i_reg_addr == `LINEAR_REG_TWO_VOLTAGE_OFS) |=> o_reg_rdata[7:5] == 3'h0)
		else $error("reserved bits not zero");
	a_fixed_one_mv: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		!i_rst && FIXED_OPTION |=> o_reg_one_mv == `FIXED_2V85_MV)
		else $error("regulator one not fixed");
	a_fixed_two_mv: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		!i_rst && FIXED_OPTION |=> o_reg_two_mv == `FIXED_2V85_MV)
		else $error("regulator two not fixed");
	a_pin_rail_on: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		i_rail_enable_pins[0] [*4] |-> o_rail_on[0])
		else $error("pin enable not honoured");
	a_bus_rail_on: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		bus_rail_en[2] |=> o_rail_on[2])
		else $error("bus enable not honoured");
	sequence s_first_step;
		state == ldo_ctrl_pkg::SEQ_UP && seq_ptr == 2'h1;
	endsequence
	a_seq_order: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		s_first_step |-> seq_rails[0] && !seq_rails[3])
		else $error("sequence order broken");
	a_seq_any_method: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		(seq_rails[1] || pin_sync[1] || bus_rail_en[1]) |=> o_rail_on[1])
		else $error("rail method not merged");
endmodule
`default_nettype wire

// ---- logic/ldo_ctrl_consts.svh ----
// Purpose: offsets, field positions, reset values and timing counts for the regulator control bank
// Assumes: 50 MHz system clock
// Notes:   included by bare name
`ifndef LDO_CTRL_CONSTS_SVH
`define LDO_CTRL_CONSTS_SVH
`define LINEAR_REG_ONE_VOLTAGE_OFS 8'h39
`define LINEAR_REG_TWO_VOLTAGE_OFS 8'h3A
`define RAIL_ENABLE_OFS            8'h3B
`define VCODE_MSB                  4
`define VCODE_LSB                  0
`define VCODE_RST                  5'h19
`define VCODE_SAT                  5'h19
`define FIXED_2V85_MV              12'hB22
`define BASE_MV                    12'h3E8
`define STEP_MV                    12'h064
`define RAIL_EN_RST                4'h0
`define SEQ_STEP_US                1000
`define CLK_MHZ                    50
`define SEQ_STEP_CYC               (`SEQ_STEP_US * `CLK_MHZ)
`endif

// ---- logic/ldo_ctrl_pkg.sv ----
// Purpose: types shared by the regulator control bank
// Assumes: nothing
// Notes:   none
`default_nettype none
package ldo_ctrl_pkg;
	typedef enum logic [2:0] {
		SEQ_OFF  = 3'b000,
		SEQ_UP   = 3'b001,
		SEQ_ON   = 3'b010,
		SEQ_DOWN = 3'b011
	} seq_state_e;
	typedef logic [4:0] vcode_t;
endpackage
`default_nettype wire

// ---- logic/ldo_vcode_decode.sv ----
// Purpose: turns a 5-bit regulator code into a target voltage in millivolts
// Assumes: same code table for both linear regulators
// Notes:   codes above the top step saturate
`timescale 1ns/1ps
`default_nettype none
`include "ldo_ctrl_consts.svh"
module ldo_vcode_decode (
	input  wire logic [4:0]  i_code,
	input  wire logic        i_fixed_option,
	output logic      [11:0] o_mv
);
	logic [4:0] sat_code;
	always_comb begin
		sat_code = (i_code > `VCODE_SAT) ? `VCODE_SAT : i_code;
		if (i_fixed_option) begin
			o_mv = `FIXED_2V85_MV;
		end else begin
			o_mv = 12'(`BASE_MV + 12'(sat_code) * `STEP_MV);
		end
	end
endmodule
`default_nettype wire

// ---- dv/ldo_host_model.sv ----
// Purpose: host side model driving bus strobes and control pins
// Assumes: block samples its inputs at the rising edge
// Notes:   expected read bytes are queued for the bench monitor
`timescale 1ns/1ps
`default_nettype none
module ldo_host_model #(
	parameter int SETTLE = 20
) (
	input  wire logic       i_clk,
	output logic            o_wr,
	output logic            o_rd,
	output logic      [7:0] o_addr,
	output logic      [7:0] o_wdata,
	output logic            o_seq,
	output logic      [3:0] o_pins
);
	logic [7:0] q[$];
	initial begin
		o_wr = 1'b0;
		o_rd = 1'b0;
		o_addr = 8'h00;
		o_wdata = 8'h00;
		o_seq = 1'b0;
		o_pins = 4'h0;
	end
	// one access; a read queues its expected byte
	task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk);
		o_wr <= w;
		o_rd <= !w;
		o_addr <= a;
		o_wdata <= d;
		if (!w) q.push_back(d);
		@(posedge i_clk);
		o_wr <= 1'b0;
		o_rd <= 1'b0;
		o_addr <= ~a;
		o_wdata <= ~d;
	endtask
	// settle wait shortened for sim; only raising needs it
	task automatic seq(input logic v);
		if (v) begin
			repeat (SETTLE) @(posedge i_clk);
		end else begin
			@(posedge i_clk);
		end
		o_seq <= v;
	endtask
	task automatic pin(input logic [3:0] v);
		@(posedge i_clk);
		o_pins <= v;
	endtask
endmodule
`default_nettype wire

// ---- dv/ldo_voltage_control_regs_tb.sv ----
// Purpose: self-checking bench for the regulator control bank
// Assumes: sequence step shortened to 4 cycles
// Notes:   read results checked by a queue monitor
`timescale 1ns/1ps
`default_nettype none
module ldo_voltage_control_regs_tb;
	logic        clk_sys;
	logic        rst = 1'b1;
	logic        wr, rd, seq, rd_seen = 1'b0;
	logic [7:0]  addr, wdata, rdata, frdata;
	logic [3:0]  pins, rail, frail;
	logic [11:0] mv1, mv2, fx1, fx2;
	logic [7:0]  b, c, exp_rd;
	int          mismatches = 0;
	int          n_checks = 0;
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	ldo_host_model host_i (.i_clk(clk_sys), .o_wr(wr), .o_rd(rd), .o_addr(addr),
		.o_wdata(wdata), .o_seq(seq), .o_pins(pins));
	ldo_voltage_control_regs #(.SEQ_STEP_CYCLES(4)) ldo_voltage_control_regs_i (
		.i_clk_sys(clk_sys), .i_rst(rst), .i_reg_wr(wr), .i_reg_rd(rd),
		.i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
		.i_seq_enable_pin(seq), .i_rail_enable_pins(pins), .o_rail_on(rail),
		.o_reg_one_mv(mv1), .o_reg_two_mv(mv2));
	// fixed factory option twin shares all inputs
	ldo_voltage_control_regs #(.SEQ_STEP_CYCLES(4), .FIXED_OPTION(1'b1)) fixed_i (
		.i_clk_sys(clk_sys), .i_rst(rst), .i_reg_wr(wr), .i_reg_rd(rd),
		.i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(frdata),
		.i_seq_enable_pin(seq), .i_rail_enable_pins(pins), .o_rail_on(frail),
		.o_reg_one_mv(fx1), .o_reg_two_mv(fx2));
	task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] s);
		n_checks++;
		if (s !== e) begin
			mismatches++;
			$display("wrong value %s exp %h got %h", nm, e, s);
		end
	endtask
	function automatic logic [11:0] mv(input logic [4:0] k);
		return (k >= 5'h19) ? 12'hDAC : 12'h3E8 + 12'h064 * k;
	endfunction
	// bounded wait, so a wrong rail order times out
	task automatic waitr(input logic [3:0] e);
		int k;
		k = 0;
		while (rail !== e && k < 50) begin
			@(posedge clk_sys);
			k++;
		end
		chk("rail", {8'h00, e}, {8'h00, rail});
		chk("fixed rail", {8'h00, e}, {8'h00, frail});
	endtask
	always @(posedge clk_sys) begin
		rd_seen <= rd;
	end
	always @(negedge clk_sys) begin
		if (rd_seen) begin
			exp_rd = host_i.q.pop_front();
			chk("rdata", {4'h0, exp_rd}, {4'h0, rdata});
			chk("fixed rdata", {4'h0, exp_rd}, {4'h0, frdata});
		end
	end
	task automatic results();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	initial begin
		#200000;
		mismatches++;
		results();
	end
	initial begin
		void'($urandom(32'h05B0B4C4));
		repeat (20) @(posedge clk_sys);
		rst <= 1'b0;
		host_i.acc(0, 8'h39, 8'h19);
		host_i.acc(0, 8'h3A, 8'h19);
		chk("mv1", 12'hDAC, mv1);
		$display("test reset done");
		// codes 17..1A with reserved bits set, then random bytes
		for (int i = 0; i < 12; i++) begin
			b = (i < 4) ? 8'hF7 + 8'(i) : 8'($urandom);
			c = 8'($urandom);
			host_i.acc(1, 8'h39, b);
			host_i.acc(1, 8'h3A, c);
			host_i.acc(0, 8'h39, b & 8'h1F);
			host_i.acc(0, 8'h3A, c & 8'h1F);
			chk("mv1", mv(b[4:0]), mv1);
			chk("mv2", mv(c[4:0]), mv2);
			chk("fx1", 12'hB22, fx1);
			chk("fx2", 12'hB22, fx2);
		end
		host_i.acc(1, 8'h40, 8'hFF);
		host_i.acc(0, 8'h40, 8'h00);
		host_i.acc(0, 8'h39, b & 8'h1F);
		$display("test codes done");
		for (int k = 0; k < 4; k++) begin
			host_i.pin(4'(1 << k));
			waitr(4'(1 << k));
		end
		host_i.pin(4'h0);
		waitr(4'h0);
		host_i.acc(1, 8'h3B, 8'h05);
		waitr(4'h5);
		host_i.acc(0, 8'h3B, 8'h55);
		host_i.acc(1, 8'h3B, 8'h00);
		waitr(4'h0);
		$display("test pins done");
		host_i.seq(1'b1);
		for (int k = 1; k < 5; k++) waitr(4'hF >> (4 - k));
		host_i.seq(1'b0);
		for (int k = 1; k < 5; k++) waitr(4'hF >> k);
		// pin dropped while still powering up must wind back to all off
		host_i.seq(1'b1);
		waitr(4'h1);
		host_i.seq(1'b0);
		waitr(4'h0);
		$display("test seq done");
		results();
	end
endmodule
`default_nettype wire
